// ==== pkg/qhc_pkg.sv ====
// Package: register map, field positions, reset values and mode codes of the quadrature counter
package qhc_pkg;
   localparam int          DATA_W        = 32;
   localparam int          ADDR_W        = 4;
   // Register offsets (word addresses)
   localparam logic [3:0]  OFF_ACC       = 4'h0;
   localparam logic [3:0]  OFF_UPPER     = 4'h1;
   localparam logic [3:0]  OFF_LOWER     = 4'h2;
   localparam logic [3:0]  OFF_CEILING   = 4'h3;
   localparam logic [3:0]  OFF_FLOOR     = 4'h4;
   localparam logic [3:0]  OFF_CTRL      = 4'h5;
   localparam logic [3:0]  OFF_STATUS    = 4'h6;
   localparam logic [3:0]  OFF_LOAD      = 4'h7;
   localparam logic [3:0]  OFF_INPUTS    = 4'h8;
   // Control fields
   localparam int          CTRL_CE_BIT   = 0;
   localparam int          CTRL_SP_BIT   = 1;
   localparam int          CTRL_MODE_LSB = 4;
   localparam int          MODE_W        = 3;
   // Status fields, write one to clear
   localparam int          ST_HIGH_BIT   = 0;
   localparam int          ST_LOW_BIT    = 1;
   localparam int          ST_OVF_BIT    = 2;
   localparam int          ST_UNF_BIT    = 3;
   localparam int          ST_ERR_BIT    = 4;
   localparam int          ST_W          = 5;
   // Modes
   localparam logic [2:0]  MODE_UP       = 3'h0;
   localparam logic [2:0]  MODE_UP_RH    = 3'h1;
   localparam logic [2:0]  MODE_QUAD     = 3'h6;
   localparam logic [2:0]  MODE_QUAD_RH  = 3'h7;
   // Reset values
   localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
   localparam logic [31:0] RST_CEILING   = 32'h7fff_ffff;
   localparam logic [31:0] RST_FLOOR     = 32'h8000_0000;
   localparam logic [2:0]  RST_MODE      = 3'h6;
endpackage

// ==== verilog/qhc_counter.sv ====
// Quadrature high-speed counter with presets, wrap limits and register port
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01: Direction follows phase order: A leads B counts up, B leads A down.
// R02: Count enabled and A leading: add one per qualifying A transition.
// R03: Count enabled and B leading: subtract one per qualifying A transition.
// R04: Mode 6 uses terminal 0 as A, terminal 1 as B; 2,3 unused.
// R05: Mode 7 adds index reset on terminal 2 and hold on terminal 3.
// R06: Mode 7 index active clears accumulator regardless of count enable.
// R07: Accumulator holds when disabled, held in mode 7, or phases static.
// R08: Accumulator is 32-bit signed, readable and writable by software.
// R09: Modes 0 and 1 clear accumulator at high preset or overflow; the accumulator counts only in modes 6 and 7, so this clear never fires.
// R10: Interrupt flag when accumulator reaches high preset.
// R11: Interrupt flag when accumulator reaches low preset.
// R12: Rising edge of set-parameters bit loads stored parameters into the counter.
// R13: Program may instead load presets by the load instruction register.
// R14: Error when loaded high preset exceeds overflow limit.
// R15: Error when loaded low preset is below underflow limit.
// R16: Increment past ceiling flags overflow and continues from floor.
// R17: Program keeps ceiling above floor within signed 32-bit range.
// R18: Error when loaded ceiling is not strictly above high preset.
// R19: Program loads a new ceiling only through a set-parameters edge.
// R20: All four input terminals stay readable whatever the counter mode.
// R21: Decrement past floor flags underflow and continues from ceiling.
module qhc_counter (
   input  wire logic        i_core_clk,
   input  wire logic        i_resetn,
   input  wire logic [3:0]  i_terminals,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   output logic             o_high_hit,
   output logic             o_low_hit,
   output logic             o_overflow,
   output logic             o_underflow,
   output logic             o_error
);
   // Three-stage input synchroniser
   logic [3:0]         sync1_q;
   logic [3:0]         sync2_q;
   logic [3:0]         sync3_q;
   logic [3:0]         pin_q;
   // Software file and working copies
   logic signed [31:0] acc_q;
   logic signed [31:0] sw_upper_q;
   logic signed [31:0] sw_lower_q;
   logic signed [31:0] sw_ceil_q;
   logic signed [31:0] sw_floor_q;
   logic signed [31:0] upper_q;
   logic signed [31:0] lower_q;
   logic signed [31:0] ceil_q;
   logic signed [31:0] floor_q;
   logic               ce_q;
   logic               sp_q;
   logic               sp_prev_q;
   logic [2:0]         mode_q;
   logic [4:0]         status_q;
   logic               high_d;
   logic               low_d;
   logic               ovf_d;
   logic               unf_d;
   logic               err_d;
   logic               sp_rise;
   logic               load_ins;
   logic               a_edge;
   logic               cnt_up;
   logic               cnt_dn;
   logic               hold;
   logic               index;
   logic               quad;
   logic signed [31:0] acc_d;

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         sync3_q <= 4'h0;
         pin_q   <= 4'h0;
      end else begin
         sync1_q <= i_terminals;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < 4; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
               pin_q[i] <= sync3_q[i];
            end
         end
      end
   end

   // Previous filtered phase levels for edge detection
   logic [1:0] phase_prev_q;
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         phase_prev_q <= 2'h0;
      end else begin
         phase_prev_q <= pin_q[1:0];
      end
   end

   always_comb begin
      quad     = (mode_q == qhc_pkg::MODE_QUAD) || (mode_q == qhc_pkg::MODE_QUAD_RH); // [R04]
      a_edge   = pin_q[0] != phase_prev_q[0];
      // A rising with B low, or A falling with B high: A leads B [R01]
      cnt_up   = a_edge && (pin_q[0] ^ pin_q[1]);
      cnt_dn   = a_edge && !(pin_q[0] ^ pin_q[1]);
      index    = (mode_q == qhc_pkg::MODE_QUAD_RH) && pin_q[2]; // [R05]
      hold     = (mode_q == qhc_pkg::MODE_QUAD_RH) && pin_q[3]; // [R05]
      sp_rise  = sp_q && !sp_prev_q;
      load_ins = i_wr && (i_addr == qhc_pkg::OFF_LOAD);
   end

   // Accumulator next value with wrap and preset detection
   always_comb begin
      acc_d  = acc_q;
      high_d = 1'b0;
      low_d  = 1'b0;
      ovf_d  = 1'b0;
      unf_d  = 1'b0;
      if (index) begin
         acc_d = qhc_pkg::RST_ZERO; // [R06]
      end else if (ce_q && !hold && quad && cnt_up) begin // [R02] [R07]
         if (acc_q >= ceil_q) begin
            acc_d = floor_q; // [R16]
            ovf_d = 1'b1;
         end else begin
            acc_d = acc_q + 32'sd1;
         end
      end else if (ce_q && !hold && quad && cnt_dn) begin // [R03] [R07]
         if (acc_q <= floor_q) begin
            acc_d = ceil_q; // [R21]
            unf_d = 1'b1;
         end else begin
            acc_d = acc_q - 32'sd1;
         end
      end
      if (acc_d != acc_q && acc_d == upper_q) begin
         high_d = 1'b1; // [R10]
      end
      if (acc_d != acc_q && acc_d == lower_q) begin
         low_d = 1'b1; // [R11]
      end
      if ((mode_q == qhc_pkg::MODE_UP || mode_q == qhc_pkg::MODE_UP_RH) && (high_d || ovf_d)) begin
         acc_d = qhc_pkg::RST_ZERO; // [R09]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         acc_q <= qhc_pkg::RST_ZERO;
      end else if (i_wr && i_addr == qhc_pkg::OFF_ACC) begin
         acc_q <= i_wdata; // [R08]
      end else begin
         acc_q <= acc_d;
      end
   end

   // Software parameter file and control bits
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         sw_upper_q <= qhc_pkg::RST_ZERO;
         sw_lower_q <= qhc_pkg::RST_ZERO;
         sw_ceil_q  <= qhc_pkg::RST_CEILING;
         sw_floor_q <= qhc_pkg::RST_FLOOR;
         ce_q       <= 1'b0;
         sp_q       <= 1'b0;
         mode_q     <= qhc_pkg::RST_MODE;
      end else if (i_wr) begin
         unique case (i_addr)
            qhc_pkg::OFF_UPPER:   sw_upper_q <= i_wdata;
            qhc_pkg::OFF_LOWER:   sw_lower_q <= i_wdata;
            qhc_pkg::OFF_CEILING: sw_ceil_q  <= i_wdata;
            qhc_pkg::OFF_FLOOR:   sw_floor_q <= i_wdata;
            qhc_pkg::OFF_CTRL: begin
               ce_q   <= i_wdata[qhc_pkg::CTRL_CE_BIT];
               sp_q   <= i_wdata[qhc_pkg::CTRL_SP_BIT];
               mode_q <= i_wdata[qhc_pkg::CTRL_MODE_LSB +: qhc_pkg::MODE_W];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         sp_prev_q <= 1'b0;
      end else begin
         sp_prev_q <= sp_q;
      end
   end

   // Working parameters; load instruction copies presets from sw_upper_q and sw_lower_q
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         upper_q <= qhc_pkg::RST_ZERO;
         lower_q <= qhc_pkg::RST_ZERO;
         ceil_q  <= qhc_pkg::RST_CEILING;
         floor_q <= qhc_pkg::RST_FLOOR;
      end else if (sp_rise) begin
         upper_q <= sw_upper_q; // [R12]
         lower_q <= sw_lower_q;
         ceil_q  <= sw_ceil_q; // [R19]
         floor_q <= sw_floor_q;
      end else if (load_ins) begin
         upper_q <= sw_upper_q; // [R13]
         lower_q <= sw_lower_q;
      end
   end

   // Parameter consistency check on each load
   always_comb begin
      err_d = 1'b0;
      if (sp_rise) begin
         err_d = (sw_upper_q > sw_ceil_q) || (sw_lower_q < sw_floor_q) || !(sw_ceil_q > sw_upper_q); // [R14] [R15] [R18]
      end else if (load_ins) begin
         err_d = (sw_upper_q > ceil_q) || (sw_lower_q < floor_q); // [R14] [R15]
      end
   end

   // Sticky status, write one to clear, set wins over clear
   logic [4:0] st_set;
   logic [4:0] st_clr;
   always_comb begin
      st_set = {err_d, unf_d, ovf_d, low_d, high_d};
      st_clr = (i_wr && i_addr == qhc_pkg::OFF_STATUS) ? i_wdata[4:0] : 5'h00;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         status_q <= 5'h00;
      end else begin
         status_q <= (status_q & ~st_clr) | st_set;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_high_hit  <= 1'b0;
         o_low_hit   <= 1'b0;
         o_overflow  <= 1'b0;
         o_underflow <= 1'b0;
         o_error     <= 1'b0;
      end else begin
         o_high_hit  <= high_d;
         o_low_hit   <= low_d;
         o_overflow  <= ovf_d;
         o_underflow <= unf_d;
         o_error     <= err_d;
      end
   end

   // Read port, data one cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         unique case (i_addr)
            qhc_pkg::OFF_ACC:     o_rdata <= acc_q;
            qhc_pkg::OFF_UPPER:   o_rdata <= sw_upper_q;
            qhc_pkg::OFF_LOWER:   o_rdata <= sw_lower_q;
            qhc_pkg::OFF_CEILING: o_rdata <= sw_ceil_q;
            qhc_pkg::OFF_FLOOR:   o_rdata <= sw_floor_q;
            qhc_pkg::OFF_CTRL:    o_rdata <= {25'h0, mode_q, 2'h0, sp_q, ce_q};
            qhc_pkg::OFF_STATUS:  o_rdata <= {27'h0, status_q};
            qhc_pkg::OFF_INPUTS:  o_rdata <= {28'h0, pin_q}; // [R20]
            default:              o_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // Assertions
   a_index_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (index && !(i_wr && i_addr == qhc_pkg::OFF_ACC)) |=> acc_q == 0) // [R06]
      else $error("index did not clear accumulator");
   a_hold_acc: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (!ce_q && !index && !(i_wr && i_addr == qhc_pkg::OFF_ACC)) |=> $stable(acc_q)) // [R07]
      else $error("accumulator moved while disabled");
   a_count_up: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (cnt_up && ce_q && !hold && !index && quad && acc_q < ceil_q && !i_wr) |=> acc_q == $past(acc_q) + 1) // [R02]
      else $error("up count missing");
   a_count_down: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (cnt_dn && ce_q && !hold && !index && quad && acc_q > floor_q && !i_wr) |=> acc_q == $past(acc_q) - 1) // [R03]
      else $error("down count missing");
   a_wrap_over: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_overflow |-> status_q[qhc_pkg::ST_OVF_BIT]) // [R16]
      else $error("overflow not latched");
   a_wrap_under: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_underflow |-> $past(acc_q) <= $past(floor_q)) // [R21]
      else $error("underflow without floor crossing");
   a_param_load: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      sp_rise |=> ceil_q == $past(sw_ceil_q) && upper_q == $past(sw_upper_q)) // [R12]
      else $error("parameters not loaded on edge");
   a_ceiling_err: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (sp_rise && !(sw_ceil_q > sw_upper_q)) |=> o_error ##0 status_q[qhc_pkg::ST_ERR_BIT]) // [R18]
      else $error("ceiling error not flagged");
   a_high_flag: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_high_hit |-> status_q[qhc_pkg::ST_HIGH_BIT]) // [R10]
      else $error("high preset flag missing");
   a_low_flag: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_low_hit |-> status_q[qhc_pkg::ST_LOW_BIT]) // [R11]
      else $error("low preset flag missing");
   a_unf_flag: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_underflow |-> status_q[qhc_pkg::ST_UNF_BIT]) // [R21]
      else $error("underflow not latched");
   a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      !$past(i_rd) |-> o_rdata == 32'h0000_0000) // [R08]
      else $error("read data outside read cycle");
   a_load_ins: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (load_ins && !sp_rise) |=> upper_q == $past(sw_upper_q) && lower_q == $past(sw_lower_q)) // [R13]
      else $error("load instruction did not copy presets");
   a_upper_err: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (sp_rise && sw_upper_q > sw_ceil_q) |=> o_error) // [R14]
      else $error("high preset error not flagged");
   a_lower_err: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (sp_rise && sw_lower_q < sw_floor_q) |=> o_error) // [R15]
      else $error("low preset error not flagged");
   a_input_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (i_rd && i_addr == qhc_pkg::OFF_INPUTS) |=> o_rdata == {28'h0, $past(pin_q)}) // [R20]
      else $error("input terminals not readable");
   c_up: cover property (@(posedge i_core_clk) disable iff (!i_resetn) cnt_up && ce_q);
   c_down: cover property (@(posedge i_core_clk) disable iff (!i_resetn) cnt_dn && ce_q);
   c_error: cover property (@(posedge i_core_clk) disable iff (!i_resetn) o_error);
   c_wrap: cover property (@(posedge i_core_clk) disable iff (!i_resetn) o_overflow);
   c_index: cover property (@(posedge i_core_clk) disable iff (!i_resetn) index);
endmodule

`default_nettype wire

// ==== verification/qhc_encoder.sv ====
// Behavioural rotary encoder with index and hold lines driving the counter terminals
`timescale 1ns/1ps
`default_nettype none
module qhc_encoder (
   input  wire logic       i_core_clk,
   output logic      [3:0] o_terminals
);
   initial o_terminals = 4'h0;

   // One quarter step, phase order gives direction
   task automatic quarter(input bit up, input int gap);
      @(posedge i_core_clk);
      if (up ^ (o_terminals[0] == o_terminals[1])) o_terminals[1] <= ~o_terminals[1];
      else o_terminals[0] <= ~o_terminals[0];
      repeat (gap) @(posedge i_core_clk);
   endtask

   // Each count is two quarter steps holding one A transition
   task automatic move(input bit up, input int n, input int gap);
      repeat (2 * n) quarter(up, gap);
   endtask

   // Index on terminal 2, hold on terminal 3
   task automatic aux(input bit idx, input bit hold);
      @(posedge i_core_clk);
      o_terminals[3:2] <= {hold, idx};
      repeat (8) @(posedge i_core_clk);
   endtask
endmodule
`default_nettype wire

// ==== verification/qhc_counter_test.sv ====
// Testbench of the quadrature counter over its register port
`timescale 1ns/1ps
`default_nettype none
module qhc_counter_test;
   logic        i_core_clk;
   logic        i_resetn;
   logic [3:0]  term;
   logic [3:0]  i_addr;
   logic [31:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [31:0] o_rdata;
   logic [4:0]  ev;
   int          ev_n [5];
   int          n_errors;
   int          n_checks;
   logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h7fffffff, 32'h80000000, 32'h60, 32'h0};
   logic [31:0] et [5][4] = '{'{5, 32'hfffffffd, 10, 32'hfffffff6}, '{20, 32'hfffffffd, 10, 32'hfffffff6},
                              '{10, 32'hfffffffd, 10, 32'hfffffff6}, '{5, 32'hfffffff5, 10, 32'hfffffff6},
                              '{5, 32'hfffffff6, 10, 32'hfffffff6}};
   int          ee [5] = '{0, 1, 2, 3, 3};

   qhc_encoder enc (.i_core_clk(i_core_clk), .o_terminals(term));
   qhc_counter uut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_terminals(term), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_high_hit(ev[0]), .o_low_hit(ev[1]),
      .o_overflow(ev[2]), .o_underflow(ev[3]), .o_error(ev[4]));

   always #4 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) for (int k = 0; k < 5; k++) if (ev[k] === 1'b1) ev_n[k]++;

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task automatic chk(input logic [3:0] a, input logic [31:0] e);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 cmp(o_rdata, e);
   endtask
   function automatic logic [31:0] ctl(input logic [2:0] m, input bit ce);
      return (32'(m) << qhc_pkg::CTRL_MODE_LSB) | 32'(ce);
   endfunction
   task automatic load(input logic [31:0] up, input logic [31:0] lo, input logic [31:0] ce, input logic [31:0] fl);
      wr(qhc_pkg::OFF_UPPER, up);
      wr(qhc_pkg::OFF_LOWER, lo);
      wr(qhc_pkg::OFF_CEILING, ce);
      wr(qhc_pkg::OFF_FLOOR, fl);
      wr(qhc_pkg::OFF_CTRL, ctl(qhc_pkg::MODE_QUAD, 1));
      wr(qhc_pkg::OFF_CTRL, ctl(qhc_pkg::MODE_QUAD, 1) | 32'h2);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge i_core_clk);
      n_errors++;
      end_sim();
   end

   initial begin
      i_core_clk = 1'b0;
      i_resetn = 1'b0;
      {i_addr, i_wdata, i_wr, i_rd} = '0;
      repeat (12) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      for (int i = 0; i < 7; i++) chk(4'(i), rv[i]);
      chk(4'hf, 32'h0);
      $display("test reset done");
      wr(qhc_pkg::OFF_CTRL, ctl(qhc_pkg::MODE_QUAD, 1));
      enc.move(1, 5, 6);
      chk(qhc_pkg::OFF_ACC, 32'h5);
      enc.move(0, 3, 12);
      chk(qhc_pkg::OFF_ACC, 32'h2);
      enc.aux(1, 1);
      chk(qhc_pkg::OFF_INPUTS, {28'h0, term});
      enc.move(1, 1, 6);
      chk(qhc_pkg::OFF_ACC, 32'h3);
      enc.aux(0, 0);
      wr(qhc_pkg::OFF_CTRL, ctl(qhc_pkg::MODE_QUAD, 0));
      enc.move(1, 2, 6);
      chk(qhc_pkg::OFF_ACC, 32'h3);
      $display("test mode6 done");
      wr(qhc_pkg::OFF_CTRL, ctl(qhc_pkg::MODE_QUAD_RH, 1));
      enc.aux(0, 1);
      enc.move(1, 2, 6);
      chk(qhc_pkg::OFF_ACC, 32'h3);
      enc.aux(0, 0);
      enc.move(1, 1, 6);
      chk(qhc_pkg::OFF_ACC, 32'h4);
      wr(qhc_pkg::OFF_CTRL, ctl(qhc_pkg::MODE_QUAD_RH, 0));
      enc.aux(1, 0);
      chk(qhc_pkg::OFF_ACC, 32'h0);
      enc.aux(0, 0);
      $display("test mode7 done");
      wr(qhc_pkg::OFF_CTRL, ctl(qhc_pkg::MODE_QUAD, 1));
      wr(qhc_pkg::OFF_ACC, 32'hfffffffe);
      chk(qhc_pkg::OFF_ACC, 32'hfffffffe);
      enc.move(1, 3, 6);
      chk(qhc_pkg::OFF_ACC, 32'h1);
      load(5, 32'hfffffffd, 10, 32'hfffffff6);
      wr(qhc_pkg::OFF_STATUS, 32'h1f);
      ev_n = '{default: 0};
      wr(qhc_pkg::OFF_ACC, 32'h3);
      enc.move(1, 2, 6);
      chk(qhc_pkg::OFF_STATUS, 32'h1 << qhc_pkg::ST_HIGH_BIT);
      cmp(32'(ev_n[0]), 32'h1);
      wr(qhc_pkg::OFF_STATUS, 32'h1f);
      chk(qhc_pkg::OFF_STATUS, 32'h0);
      enc.move(0, 8, 6);
      chk(qhc_pkg::OFF_ACC, 32'hfffffffd);
      cmp(32'(ev_n[1]), 32'h1);
      wr(qhc_pkg::OFF_ACC, 32'h9);
      enc.move(1, 3, 6);
      chk(qhc_pkg::OFF_ACC, 32'hfffffff7);
      cmp(32'(ev_n[2]), 32'h1);
      enc.move(0, 2, 6);
      chk(qhc_pkg::OFF_ACC, 32'ha);
      cmp(32'(ev_n[3]), 32'h1);
      $display("test presets done");
      wr(qhc_pkg::OFF_UPPER, 32'h7);
      wr(qhc_pkg::OFF_ACC, 32'h6);
      enc.move(1, 1, 6);
      cmp(32'(ev_n[0]), 32'h1);
      wr(qhc_pkg::OFF_LOAD, 32'h0);
      wr(qhc_pkg::OFF_ACC, 32'h6);
      enc.move(1, 1, 6);
      chk(qhc_pkg::OFF_ACC, 32'h7);
      cmp(32'(ev_n[0]), 32'h2);
      $display("test load done");
      for (int i = 0; i < 5; i++) begin
         load(et[i][0], et[i][1], et[i][2], et[i][3]);
         chk(qhc_pkg::OFF_UPPER, et[i][0]);
         cmp(32'(ev_n[4]), 32'(ee[i]));
      end
      $display("test errors done");
      end_sim();
   end
endmodule
`default_nettype wire
